// ---- modem_model.sv ----
// Behavioural modem on the line side of one UART channel.
// Assumes the bench commands which handshake lines the modem asserts.
`timescale 1ns/1ps
module modem_model (
  input  wire logic i_ref_clk,
  input  wire logic i_cts_on,
  input  wire logic i_dsr_on,
  input  wire logic i_tx_pin,
  output logic      o_cts_n = 1'b1,
  output logic      o_dsr_n = 1'b1,
  output logic      o_rx_line
);
  // Handshake inputs of the channel are active low, launched on the clock
  always @(posedge i_ref_clk) begin
    o_cts_n <= ~i_cts_on;
    o_dsr_n <= ~i_dsr_on;
  end
  // Null-modem style: the line we send back mirrors the channel output
  assign o_rx_line = i_tx_pin;
endmodule : modem_model

// ---- rx_err_fifo.sv ----
// Receive character store that keeps the error flags beside each character.
// Assumes push and pop are single-cycle strobes qualified by the clock enable.
`timescale 1ns/1ps
module rx_err_fifo (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  rx_fifo_if.fifo  f
);
  logic [uart_mcr_lsr_pkg::ENTRY_W-1:0] mem [0:uart_mcr_lsr_pkg::FIFO_DEPTH-1];
  logic [uart_mcr_lsr_pkg::PTR_W-1:0]   wr_ptr_reg;
  logic [uart_mcr_lsr_pkg::PTR_W-1:0]   rd_ptr_reg;
  logic [uart_mcr_lsr_pkg::CNT_W-1:0]   count_reg;
  logic [uart_mcr_lsr_pkg::CNT_W-1:0]   err_cnt_reg;
  logic                                 full;
  logic                                 push_ok;
  logic                                 pop_ok;
  logic                                 push_err;
  logic                                 pop_err;

  // A full store drops the new character; the drop is reported as overrun
  assign full     = (count_reg == uart_mcr_lsr_pkg::FIFO_FULL_CNT);
  assign push_ok  = f.push & ~full;
  assign pop_ok   = f.pop & (count_reg != '0);
  assign push_err = push_ok & (|f.push_flags);
  assign pop_err  = pop_ok & (|f.head_flags);

  // Head entry and summaries
  assign f.head_data  = mem[rd_ptr_reg][7:0];
  assign f.head_flags = mem[rd_ptr_reg][10:8];
  assign f.not_empty  = (count_reg != '0);
  assign f.err_any    = (err_cnt_reg != '0);
  assign f.overrun    = f.push & full & i_clk_en;

  // Storage; a break stores a zero character whatever the receiver shifted in
  always_ff @(posedge i_ref_clk) begin
    if (i_clk_en && push_ok) begin
      mem[wr_ptr_reg] <= {f.push_flags,
                          f.push_flags[2] ? uart_mcr_lsr_pkg::BREAK_CHAR : f.push_data};
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (i_clk_en) begin
      if (push_ok) wr_ptr_reg <= wr_ptr_reg + 6'h01;
      if (pop_ok) rd_ptr_reg <= rd_ptr_reg + 6'h01;
      if (push_ok && !pop_ok) count_reg <= count_reg + 7'h01;
      else if (pop_ok && !push_ok) count_reg <= count_reg - 7'h01;
    end
  end

  // Count of stored characters carrying any error, so the summary clears exactly
  // when the last bad character leaves
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      err_cnt_reg <= '0;
    end else if (i_clk_en) begin
      if (push_err && !pop_err) err_cnt_reg <= err_cnt_reg + 7'h01;
      else if (pop_err && !push_err) err_cnt_reg <= err_cnt_reg - 7'h01;
    end
  end
endmodule : rx_err_fifo

// ---- rx_fifo_if.sv ----
// Bundle between the status logic and the receive character store.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface rx_fifo_if;
  logic       push;
  logic [7:0] push_data;
  logic [2:0] push_flags;    // {break, framing, parity}
  logic       pop;
  logic [7:0] head_data;
  logic [2:0] head_flags;
  logic       not_empty;
  logic       err_any;
  logic       overrun;       // Push attempted while full, one cycle

  modport fifo (input push, push_data, push_flags, pop,
                output head_data, head_flags, not_empty, err_any, overrun);
  modport ctrl (output push, push_data, push_flags, pop,
                input head_data, head_flags, not_empty, err_any, overrun);
endinterface : rx_fifo_if

// ---- tb.sv ----
// Self-checking bench for the modem control and line status block.
// Assumes a 100 MHz clock and index-addressed strobes as the host port.
`timescale 1ns/1ps
module tb;
  localparam logic [3:0] MCR = uart_mcr_lsr_pkg::ADDR_MCR;
  localparam logic [3:0] LSR = uart_mcr_lsr_pkg::ADDR_LSR;
  localparam logic [3:0] RECEIVE_HOLDING_REG = uart_mcr_lsr_pkg::ADDR_RHR;
  logic       clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, enh = 1'b0;
  logic       a_en = 1'b0, a_n = 1'b1, dsel = 1'b0, g_wr = 1'b0, txs = 1'b1;
  logic       transmit_holding_reg = 1'b1, transmit_shift_reg = 1'b1, push = 1'b0, brk = 1'b0, fe = 1'b0, pe = 1'b0;
  logic       en = 1'b1;
  logic       cts_on = 1'b0, dsr_on = 1'b0, cts_n, dsr_n, rx_line;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, g_data = 8'h00, rx_d = 8'h00;
  logic [7:0] rdata, gpio, lsr_o;
  logic       valid, tick, irda, xon, loopb, thr_acc, rts_n, cts_st, dsr_st, tx_pin, rx_ser;
  int         mismatches = 0;
  int         num_checks = 0;

  uart_modem_ctrl_line_status i_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_clk_en(en), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_enh_write_en(enh), .i_auto_rts_en(a_en),
    .i_auto_rts_n(a_n), .i_dtr_pin_sel(dsel), .i_gpio_state_wr(g_wr), .i_gpio_state_wdata(g_data),
    .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_tx_serial(txs), .i_rx_pin(rx_line), .i_thr_empty(transmit_holding_reg),
    .i_tsr_empty(transmit_shift_reg), .i_rx_push(push), .i_rx_data(rx_d), .i_rx_break(brk), .i_rx_frame_err(fe),
    .i_rx_parity_err(pe), .o_reg_rdata(rdata), .o_rdata_valid(valid), .o_baud_tick(tick),
    .o_irda_mode(irda), .o_xon_any(xon), .o_loopback(loopb), .o_thresh_access(thr_acc),
    .o_rts_n(rts_n), .o_gpio_out(gpio), .o_cts_state(cts_st), .o_dsr_state(dsr_st),
    .o_tx_pin(tx_pin), .o_rx_serial(rx_ser), .o_line_status(lsr_o));
  modem_model i_modem (.i_ref_clk(clk), .i_cts_on(cts_on), .i_dsr_on(dsr_on), .i_tx_pin(tx_pin),
    .o_cts_n(cts_n), .o_dsr_n(dsr_n), .o_rx_line(rx_line));

  // Free-running core clock
  always #5 clk = ~clk;

  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  // Read strobe lasts one edge; the answer is awaited under a bound
  task automatic rdc(input logic [3:0] a, input string what, input logic [7:0] exp);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    for (int n = 0; n < 4 && valid !== 1'b1; n++) cyc(1);
    if (valid !== 1'b1) begin
      mismatches++;
      end_sim();
    end
    chk(what, rdata, exp);
  endtask : rdc

  task automatic rx_push(input logic [7:0] d, input logic [2:0] f);
    @(posedge clk);
    push <= 1'b1;
    rx_d <= d;
    {brk, fe, pe} <= f;
    @(posedge clk);
    push <= 1'b0;
  endtask : rx_push

  // Protected fields, mode outputs and prescaler tick rate
  task automatic t_ctrl();
    int ticks;
    rdc(MCR, "mcr_reset", 8'h00);
    wr(MCR, 8'hff);
    rdc(MCR, "mcr_locked", 8'h13);
    @(posedge clk);
    enh <= 1'b1;
    wr(MCR, 8'hff);
    rdc(MCR, "mcr_open", 8'hf7);
    for (int m = 0; m < 2; m++) begin
      cyc(2);
      chk("modes", {4'h0, irda, xon, loopb, thr_acc}, m ? 8'h00 : 8'h0f);
      ticks = 0;
      repeat (8) begin
        cyc(1);
        ticks += int'(tick === 1'b1);
      end
      chk("ticks", 8'(ticks), m ? 8'h08 : 8'h02);
      wr(MCR, 8'h00);
    end
    // A write while the clock enable is low must leave the register untouched
    @(posedge clk);
    en <= 1'b0;
    wr(MCR, 8'h03);
    @(posedge clk);
    en <= 1'b1;
    rdc(MCR, "mcr_frozen", 8'h00);
  endtask : t_ctrl

  // Handshake pins under register, auto-RTS and GPIO writes
  task automatic t_pins();
    wr(MCR, 8'h03);
    @(posedge clk);
    dsel <= 1'b1;
    g_wr <= 1'b1;
    g_data <= 8'hff;
    @(posedge clk);
    g_wr <= 1'b0;
    cyc(2);
    chk("rts_dtr_on", {6'h00, rts_n, gpio[5]}, 8'h00);
    chk("gpio", gpio, 8'hdf);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      a_en <= 1'b1;
      a_n <= v[0];
      cyc(2);
      chk("auto_rts", {7'h00, rts_n}, 8'(v));
    end
    @(posedge clk);
    a_en <= 1'b0;
    wr(MCR, 8'h00);
    cyc(2);
    chk("rts_dtr_off", {6'h00, rts_n, gpio[5]}, 8'h03);
  endtask : t_pins

  // Loopback against normal routing, modem asserting CTS only
  task automatic t_loop();
    @(posedge clk);
    cts_on <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr(MCR, m ? 8'h11 : 8'h00);
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        txs <= v[0];
        cyc(4);
        chk("line_loop", {4'h0, rx_ser, tx_pin, cts_st, dsr_st},
            m ? {4'h0, v[0], 3'b101} : {4'h0, v[0], v[0], 2'b10});
      end
    end
    wr(MCR, 8'h00);
  endtask : t_loop

  // Transmitter emptiness flags over all four input combinations
  task automatic t_tx();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      {transmit_holding_reg, transmit_shift_reg} <= 2'(k);
      cyc(3);
      chk("tx_status", lsr_o & 8'h60, {1'b0, k == 3, k >= 2, 5'h00});
    end
  endtask : t_tx

  // Characters with each error kind, read status first, then data
  task automatic t_rx();
    logic [7:0] ls[5] = '{8'he1, 8'hf1, 8'he9, 8'he5, 8'h60};
    logic [7:0] rh[4] = '{8'h41, 8'h00, 8'h66, 8'h77};
    rx_push(8'h41, 3'b000);
    rx_push(8'h55, 3'b100);
    rx_push(8'h66, 3'b010);
    rx_push(8'h77, 3'b001);
    cyc(3);
    for (int i = 0; i < 5; i++) begin
      rdc(LSR, "lsr", ls[i]);
      if (i < 4) rdc(RECEIVE_HOLDING_REG, "rhr", rh[i]);
      cyc(2);
    end
  endtask : t_rx

  // One push beyond the 64-entry store, then a full drain
  task automatic t_ovr();
    for (int i = 0; i < 65; i++) rx_push(8'(i), 3'b000);
    cyc(3);
    rdc(LSR, "overrun_set", 8'h63);
    rdc(LSR, "overrun_clr", 8'h61);
    for (int i = 0; i < 64; i++) rdc(RECEIVE_HOLDING_REG, "drain", 8'(i));
    cyc(2);
    rdc(LSR, "empty", 8'h60);
  endtask : t_ovr

  // Main sequence: reset, then each scenario in turn
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk("idle_pins", {6'h00, rts_n, tx_pin}, 8'h03);
    t_ctrl();
    t_pins();
    t_loop();
    t_tx();
    t_rx();
    t_ovr();
    end_sim();
  end
endmodule : tb

// ---- uart_mcr_lsr_pkg.sv ----
// Constants for the modem control and line status block of one UART channel.
// Assumes a single 100 MHz core clock; register indices are those of the host port.
package uart_mcr_lsr_pkg;
  // Register indices on the host register port
  localparam logic [3:0] ADDR_RHR = 4'h0;
  localparam logic [3:0] ADDR_MCR = 4'h4;
  localparam logic [3:0] ADDR_LSR = 4'h5;

  // Modem control field positions
  localparam int MCR_DIV4    = 7;
  localparam int MCR_IRDA    = 6;
  localparam int MCR_XON_ANY = 5;
  localparam int MCR_LOOP    = 4;
  localparam int MCR_THRESH  = 2;
  localparam int MCR_RTS     = 1;
  localparam int MCR_DTR     = 0;

  // Reset value, write-protected field mask and reserved mask of modem control
  localparam logic [7:0] MCR_RESET     = 8'h00;
  localparam logic [7:0] MCR_PROT_MASK = 8'he4;
  localparam logic [7:0] MCR_RSVD_MASK = 8'h08;

  // Line status field positions
  localparam int LSR_FIFO_ERR = 7;
  localparam int LSR_TX_EMPTY = 6;
  localparam int LSR_THR_EMPTY = 5;
  localparam int LSR_BREAK    = 4;
  localparam int LSR_FRAME    = 3;
  localparam int LSR_PARITY   = 2;
  localparam int LSR_OVERRUN  = 1;
  localparam int LSR_DATA_RDY = 0;
  localparam logic [7:0] LSR_RESET = 8'h60;

  // Receive FIFO geometry; an entry is {break, framing, parity, data}
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W      = 6;
  localparam int CNT_W      = 7;
  localparam int ENTRY_W    = 11;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 7'h40;
  localparam logic [7:0] BREAK_CHAR = 8'h00;

  // Prescaler: last count value when divide-by-four is selected, one below the four cycles per tick
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // GPIO bit that serves as the data-terminal-ready pin on this channel
  localparam int DTR_GPIO_BIT = 5;
  localparam logic [7:0] GPIO_RESET = 8'h00;
endpackage : uart_mcr_lsr_pkg

// ---- uart_modem_ctrl_line_status.sv ----
// Modem control and line status logic of one UART channel.
// Assumes a host register port already decoded to a 4-bit index, and that the
// enhanced-feature write enable, GPIO config and auto-RTS logic live outside.
// How it works
// - Prescaler bit selects divide by one or four
// - Infrared bit selects infrared encoding mode
// - Resume-on-any bit enables any-character resume
// - Loopback routes transmit output into receive input
// - Loopback feeds RTS/DTR bits into CTS/DSR status
// - Bit 2 opens threshold and trigger registers
// - RTS pin low when bit 1 set, outside loopback
// - Auto RTS overrides bit 1 on pin
// - DTR pin low when bit 0 set, outside loopback
// - GPIO state writes ignored on DTR pin
// - Bits 7..5 and 2 need enhanced enable
// - FIFO error bit while any bad character
// - Transmit empty needs holding and shift empty
// - Holding empty flag allows 64-character load
// - Full-frame low line flags break, zero stored
// - Framing flag of character being read
// - Parity flag of character being read
// - Overrun bit set on overrun only
// - Data-ready while receive FIFO not empty
// - Status read shows head character flags
`timescale 1ns/1ps
module uart_modem_ctrl_line_status (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clk_en,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [3:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_enh_write_en,
  input  wire logic       i_auto_rts_en,
  input  wire logic       i_auto_rts_n,
  input  wire logic       i_dtr_pin_sel,
  input  wire logic       i_gpio_state_wr,
  input  wire logic [7:0] i_gpio_state_wdata,
  input  wire logic       i_cts_n,
  input  wire logic       i_dsr_n,
  input  wire logic       i_tx_serial,
  input  wire logic       i_rx_pin,
  input  wire logic       i_thr_empty,
  input  wire logic       i_tsr_empty,
  input  wire logic       i_rx_push,
  input  wire logic [7:0] i_rx_data,
  input  wire logic       i_rx_break,
  input  wire logic       i_rx_frame_err,
  input  wire logic       i_rx_parity_err,
  output logic [7:0]      o_reg_rdata,
  output logic            o_rdata_valid,
  output logic            o_baud_tick,
  output logic            o_irda_mode,
  output logic            o_xon_any,
  output logic            o_loopback,
  output logic            o_thresh_access,
  output logic            o_rts_n,
  output logic [7:0]      o_gpio_out,
  output logic            o_cts_state,
  output logic            o_dsr_state,
  output logic            o_tx_pin,
  output logic            o_rx_serial,
  output logic [7:0]      o_line_status
);
  rx_fifo_if rxf ();

  logic [7:0] modem_control_reg;
  logic [7:0] modem_control_next;
  logic [7:0] line_status_reg;
  logic [7:0] line_status_next;
  logic [7:0] gpio_pin_state_reg;
  logic       overrun_reg;
  logic [1:0] prescale_reg;
  logic       mcr_wr;
  logic       lsr_rd;
  logic       rhr_rd;
  logic [7:0] mcr_mask;

  // Address decode shared by read and write paths
  function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  assign mcr_wr = i_reg_wr & addr_hit(i_reg_addr, uart_mcr_lsr_pkg::ADDR_MCR);
  assign lsr_rd = i_reg_rd & addr_hit(i_reg_addr, uart_mcr_lsr_pkg::ADDR_LSR);
  assign rhr_rd = i_reg_rd & addr_hit(i_reg_addr, uart_mcr_lsr_pkg::ADDR_RHR);

  // Protected fields only take a write while the enhanced write enable is set
  assign mcr_mask = i_enh_write_en ? ~uart_mcr_lsr_pkg::MCR_RSVD_MASK
                                   : ~(uart_mcr_lsr_pkg::MCR_PROT_MASK | uart_mcr_lsr_pkg::MCR_RSVD_MASK);
  assign modem_control_next = (modem_control_reg & ~mcr_mask) | (i_reg_wdata & mcr_mask);

  // Receive store hookup; reading the holding register retires the head character
  assign rxf.push       = i_rx_push & i_clk_en;
  assign rxf.push_data  = i_rx_data;
  assign rxf.push_flags = {i_rx_break, i_rx_frame_err, i_rx_parity_err};
  assign rxf.pop        = rhr_rd & i_clk_en;

  rx_err_fifo u_rx_store (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .f         (rxf)
  );

  // Live line status; head flags are masked when nothing is stored
  always_comb begin
    line_status_next = 8'h00;
    line_status_next[uart_mcr_lsr_pkg::LSR_FIFO_ERR]  = rxf.err_any;
    line_status_next[uart_mcr_lsr_pkg::LSR_TX_EMPTY]  = i_thr_empty & i_tsr_empty;
    line_status_next[uart_mcr_lsr_pkg::LSR_THR_EMPTY] = i_thr_empty;
    line_status_next[uart_mcr_lsr_pkg::LSR_BREAK]     = rxf.not_empty & rxf.head_flags[2];
    line_status_next[uart_mcr_lsr_pkg::LSR_FRAME]     = rxf.not_empty & rxf.head_flags[1];
    line_status_next[uart_mcr_lsr_pkg::LSR_PARITY]    = rxf.not_empty & rxf.head_flags[0];
    line_status_next[uart_mcr_lsr_pkg::LSR_OVERRUN]   = overrun_reg;
    line_status_next[uart_mcr_lsr_pkg::LSR_DATA_RDY]  = rxf.not_empty;
  end

  // Modem control register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      modem_control_reg <= uart_mcr_lsr_pkg::MCR_RESET;
    end else if (i_clk_en && mcr_wr) begin
      modem_control_reg <= modem_control_next;
    end
  end

  // Sticky overrun, cleared by a status read; a new overrun in the same cycle wins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      overrun_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (rxf.overrun) overrun_reg <= 1'b1;
      else if (lsr_rd) overrun_reg <= 1'b0;
    end
  end

  // Status register view and host read data
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      line_status_reg <= uart_mcr_lsr_pkg::LSR_RESET;
      o_reg_rdata     <= 8'h00;
      o_rdata_valid   <= 1'b0;
    end else if (i_clk_en) begin
      line_status_reg <= line_status_next;
      o_rdata_valid   <= i_reg_rd;
      if (lsr_rd) o_reg_rdata <= line_status_next;
      else if (rhr_rd) o_reg_rdata <= rxf.not_empty ? rxf.head_data : 8'h00;
      else if (i_reg_rd && addr_hit(i_reg_addr, uart_mcr_lsr_pkg::ADDR_MCR)) o_reg_rdata <= modem_control_reg;
      else if (i_reg_rd) o_reg_rdata <= 8'h00;
    end
  end

  // Prescaler: a tick every cycle, or every fourth cycle when divide-by-four is set
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prescale_reg <= 2'h0;
      o_baud_tick  <= 1'b0;
    end else if (i_clk_en) begin
      if (!modem_control_reg[uart_mcr_lsr_pkg::MCR_DIV4]) begin
        prescale_reg <= 2'h0;
        o_baud_tick  <= 1'b1;
      end else begin
        prescale_reg <= (prescale_reg == uart_mcr_lsr_pkg::PRESCALE_LAST) ? 2'h0 : prescale_reg + 2'h1;
        o_baud_tick  <= (prescale_reg == uart_mcr_lsr_pkg::PRESCALE_LAST);
      end
    end
  end

  // Mode outputs taken straight from the control fields
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irda_mode     <= 1'b0;
      o_xon_any       <= 1'b0;
      o_loopback      <= 1'b0;
      o_thresh_access <= 1'b0;
    end else if (i_clk_en) begin
      o_irda_mode     <= modem_control_reg[uart_mcr_lsr_pkg::MCR_IRDA];
      o_xon_any       <= modem_control_reg[uart_mcr_lsr_pkg::MCR_XON_ANY];
      o_loopback      <= modem_control_reg[uart_mcr_lsr_pkg::MCR_LOOP];
      o_thresh_access <= modem_control_reg[uart_mcr_lsr_pkg::MCR_THRESH];
    end
  end

  // Serial path; in loopback the line pin idles high so the far end sees nothing
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_pin    <= 1'b1;
      o_rx_serial <= 1'b1;
    end else if (i_clk_en) begin
      if (modem_control_reg[uart_mcr_lsr_pkg::MCR_LOOP]) begin
        o_tx_pin    <= 1'b1;
        o_rx_serial <= i_tx_serial;
      end else begin
        o_tx_pin    <= i_tx_serial;
        o_rx_serial <= i_rx_pin;
      end
    end
  end

  // Handshake status bits and RTS pin; loopback keeps the pin inactive
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cts_state <= 1'b0;
      o_dsr_state <= 1'b0;
      o_rts_n     <= 1'b1;
    end else if (i_clk_en) begin
      if (modem_control_reg[uart_mcr_lsr_pkg::MCR_LOOP]) begin
        o_cts_state <= modem_control_reg[uart_mcr_lsr_pkg::MCR_RTS];
        o_dsr_state <= modem_control_reg[uart_mcr_lsr_pkg::MCR_DTR];
        o_rts_n     <= 1'b1;
      end else begin
        o_cts_state <= ~i_cts_n;
        o_dsr_state <= ~i_dsr_n;
        o_rts_n     <= i_auto_rts_en ? i_auto_rts_n
                                     : ~modem_control_reg[uart_mcr_lsr_pkg::MCR_RTS];
      end
    end
  end

  // GPIO state; the bit that serves as DTR ignores host writes
  generate
    for (genvar b = 0; b < 8; b++) begin : g_gpio
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          gpio_pin_state_reg[b] <= uart_mcr_lsr_pkg::GPIO_RESET[b];
        end else if (i_clk_en && i_gpio_state_wr &&
                     !(i_dtr_pin_sel && (b == uart_mcr_lsr_pkg::DTR_GPIO_BIT))) begin
          gpio_pin_state_reg[b] <= i_gpio_state_wdata[b];
        end
      end
    end
  endgenerate

  // GPIO pins; DTR pin is active low, inactive during loopback
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_gpio_out <= uart_mcr_lsr_pkg::GPIO_RESET;
    end else if (i_clk_en) begin
      o_gpio_out <= gpio_pin_state_reg;
      if (i_dtr_pin_sel) begin
        o_gpio_out[uart_mcr_lsr_pkg::DTR_GPIO_BIT] <= modem_control_reg[uart_mcr_lsr_pkg::MCR_LOOP] ? 1'b1
                                                      : ~modem_control_reg[uart_mcr_lsr_pkg::MCR_DTR];
      end
    end
  end

  assign o_line_status = line_status_reg;

  // Checks, all in the core clock domain
  sequence s_mcr_write_locked;
    i_clk_en && mcr_wr && !i_enh_write_en;
  endsequence

  sequence s_div4_tick;
    i_clk_en && o_baud_tick && modem_control_reg[uart_mcr_lsr_pkg::MCR_DIV4];
  endsequence

  protect_bits_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_mcr_write_locked |=> (modem_control_reg & uart_mcr_lsr_pkg::MCR_PROT_MASK) ==
                           ($past(modem_control_reg) & uart_mcr_lsr_pkg::MCR_PROT_MASK))
    else $error("Protected control bits changed without enhanced enable");

  prescale_gap_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_div4_tick ##1 (i_clk_en && modem_control_reg[uart_mcr_lsr_pkg::MCR_DIV4]) |-> !o_baud_tick)
    else $error("Divide-by-four tick repeated on next cycle");

  prescale_div1_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && !modem_control_reg[uart_mcr_lsr_pkg::MCR_DIV4]) |=> o_baud_tick)
    else $error("Divide-by-one tick missing");

  loop_path_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && modem_control_reg[uart_mcr_lsr_pkg::MCR_LOOP]) |=> (o_rx_serial == $past(i_tx_serial)) && o_tx_pin)
    else $error("Loopback serial path wrong");

  loop_cts_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && modem_control_reg[uart_mcr_lsr_pkg::MCR_LOOP]) |=>
      (o_cts_state == $past(modem_control_reg[uart_mcr_lsr_pkg::MCR_RTS])) &&
      (o_dsr_state == $past(modem_control_reg[uart_mcr_lsr_pkg::MCR_DTR])) && o_rts_n)
    else $error("Loopback handshake status wrong");

  auto_rts_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && i_auto_rts_en && !modem_control_reg[uart_mcr_lsr_pkg::MCR_LOOP]) |=> o_rts_n == $past(i_auto_rts_n))
    else $error("RTS pin not following flow control");

  manual_rts_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && !i_auto_rts_en && !modem_control_reg[uart_mcr_lsr_pkg::MCR_LOOP]) |=>
      o_rts_n == !$past(modem_control_reg[uart_mcr_lsr_pkg::MCR_RTS]))
    else $error("RTS pin not following control bit");

  tx_empty_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && !(i_thr_empty && i_tsr_empty)) |=> !line_status_reg[uart_mcr_lsr_pkg::LSR_TX_EMPTY])
    else $error("Transmit empty reported while busy");

  overrun_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && rxf.overrun) |=> overrun_reg ##1 (overrun_reg || $past(lsr_rd)))
    else $error("Overrun flag lost");

  data_ready_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && rxf.push && !rxf.not_empty) |=> ##1 line_status_reg[uart_mcr_lsr_pkg::LSR_DATA_RDY] || !i_clk_en)
    else $error("Data ready missing after first character");

  dtr_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && i_dtr_pin_sel) |=> $stable(gpio_pin_state_reg[uart_mcr_lsr_pkg::DTR_GPIO_BIT]))
    else $error("DTR pin state bit took a write");
endmodule : uart_modem_ctrl_line_status
